// ==== core/ckp_clock_status_prescaler.sv ====
// Notes on behaviour
// - The 3-bit switch status reads 010 HSE, 011 HSI, 110 LSE, 111 LSI, 00x reserved.
// - The HSI usage field sets bit 0 when HSI is the system clock and bit 2 for the monitor.
// - The HSE usage field sets bit 0 when the crystal is the system clock.
// - Status fields are read-only and follow hardware continuously.
// - An ordinary select divides the bus clock by 1, 2, 4 or 8 for codes 00 to 11.
// - Motor timer, second and first basic timer selects sit at 17:16, 15:14, 13:12.
// - Second and first SPI selects sit at 7:6 and 5:4.
// - Second and first two-wire selects sit at 3:2 and 1:0.
// - The always-on register access select divides by 4, 8, 16 or 32.
// - The alternate-function I/O select at bits 1:0 of register b uses ordinary encoding.
`timescale 1ns/1ns
module ckp_clock_status_prescaler
    import ckp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] clock_switch_select,
    input wire logic monitor_uses_hsi,
    output logic [CKP_NCLK-1:0] periph_clk_en
);

    ckp_state_t s_q;
    ckp_state_t s_d;
    logic [2:0] src_meta_q;
    logic [2:0] src_sync_q;
    logic mon_meta_q;
    logic mon_sync_q;

    // Maps a 2-bit select to a divide exponent; the always-on select adds two.
    function automatic logic [2:0] ckp_ratio(input logic [1:0] code, input logic aon);
        ckp_ratio = aon ? ({1'b0, code} + 3'h2) : {1'b0, code};
    endfunction : ckp_ratio

    // Applies byte strobes and the writable mask to a register.
    function automatic logic [31:0] ckp_write(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        ckp_write = (old & ~m) | (wd & m);
    endfunction : ckp_write

    // Two-flop synchronisers for the clock-source inputs from the clock switch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta_q <= CKP_SRC_HSI;
            src_sync_q <= CKP_SRC_HSI;
            mon_meta_q <= 1'b0;
            mon_sync_q <= 1'b0;
        end else begin
            src_meta_q <= clock_switch_select;
            src_sync_q <= src_meta_q;
            mon_meta_q <= monitor_uses_hsi;
            mon_sync_q <= mon_meta_q;
        end
    end

    // Next-state logic: bus slave, status tracking and dividers.
    always_comb begin
        logic setup;
        logic access;
        logic [CKP_NCLK*2-1:0] codes;
        logic [CKP_NCLK-1:0] aon;
        logic [2:0] r;
        logic [CKP_CW-1:0] lim;
        setup = psel && !penable;
        access = psel && penable;
        codes = '0;
        aon = '0;
        r = '0;
        lim = '0;
        s_d = s_q;
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        // Status follows the synchronised switch state every cycle.
        s_d.swst = src_sync_q;
        s_d.int_usage = {mon_sync_q, 1'b0, (src_sync_q == CKP_SRC_HSI)};
        s_d.hse_used = (src_sync_q == CKP_SRC_HSE);
        // Read data is captured in the setup cycle and shown in the access cycle.
        if (setup) begin
            s_d.prdata = '0;
            s_d.pslverr = (paddr[1:0] != 2'h0);
            unique case (paddr)
                CKP_STATUS_OFF: begin
                    s_d.prdata[CKP_SWST_LSB +: 3] = s_q.swst;
                    s_d.prdata[CKP_EXT_USE_LSB] = s_q.hse_used;
                    s_d.prdata[CKP_INT_USE_LSB +: 3] = s_q.int_usage;
                    s_d.pslverr = pwrite;
                end
                CKP_SEL_A_OFF: s_d.prdata = s_q.sel_a;
                CKP_SEL_B_OFF: s_d.prdata = s_q.sel_b;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        // Writes land on the access cycle; the status register ignores them.
        if (access && pwrite && s_q.pready) begin
            if (paddr == CKP_SEL_A_OFF) begin
                s_d.sel_a = ckp_write(s_q.sel_a, pwdata, pstrb, CKP_SEL_A_MASK);
            end
            if (paddr == CKP_SEL_B_OFF) begin
                s_d.sel_b = ckp_write(s_q.sel_b, pwdata, pstrb, CKP_SEL_B_MASK);
            end
        end
        // Gather the selects in output order.
        codes = {s_q.sel_b[CKP_AFIO_LSB +: 2], s_q.sel_b[CKP_AON_LSB +: 2],
                 s_q.sel_a[CKP_MOTOR_LSB +: 2], s_q.sel_a[CKP_BT1_LSB +: 2],
                 s_q.sel_a[CKP_BT0_LSB +: 2], s_q.sel_a[CKP_SPI1_LSB +: 2],
                 s_q.sel_a[CKP_SPI0_LSB +: 2], s_q.sel_a[CKP_TW1_LSB +: 2],
                 s_q.sel_a[CKP_TW0_LSB +: 2]};
        aon[7] = 1'b1;
        // Free-running counter; each output pulses once per 2**ratio cycles.
        s_d.cnt = s_q.cnt + {{(CKP_CW-1){1'b0}}, 1'b1};
        for (int i = 0; i < CKP_NCLK; i++) begin
            r = s_q.ratio[i*3 +: 3];
            lim = CKP_CW'((1 << r) - 1);
            s_d.clk_en[i] = ((s_q.cnt & lim) == lim);
            // Take the new ratio only at the edge closing the current period.
            if ((s_q.cnt & lim) == lim) begin
                s_d.ratio[i*3 +: 3] = ckp_ratio(codes[i*2 +: 2], aon[i]);
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{sel_a: CKP_SEL_A_RST, sel_b: CKP_SEL_B_RST,
                     swst: CKP_STATUS_RST[CKP_SWST_LSB +: 3],
                     int_usage: CKP_STATUS_RST[CKP_INT_USE_LSB +: 3],
                     hse_used: CKP_STATUS_RST[CKP_EXT_USE_LSB],
                     cnt: '0, ratio: CKP_RATIO_RST, clk_en: '0,
                     prdata: '0, pready: 1'b0, pslverr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign periph_clk_en = s_q.clk_en;

    // Switch status follows the synchronised select one cycle later.
    a_swst_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (s_q.swst == $past(src_sync_q)))
        else $error("switch status lags its source");

    a_hsi_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (src_sync_q == CKP_SRC_HSI) |=> s_q.int_usage[0] && !s_q.int_usage[1])
        else $error("internal fast usage bit not set");

    a_hse_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (src_sync_q == CKP_SRC_HSE) |=> s_q.hse_used)
        else $error("external fast usage bit not set");

    a_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite && paddr == CKP_STATUS_OFF) |=> pslverr && pready)
        else $error("status write not refused");

    a_undiv_clk: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[2:0] == 3'h0) |=> s_q.clk_en[0])
        else $error("undivided clock enable missing");

    a_div8_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[5:3] == 3'h3 && $stable(s_q.ratio[5:3]) && s_q.clk_en[1])
        |=> !s_q.clk_en[1] [*7])
        else $error("divide by eight spacing wrong");

    a_aon_min4: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.clk_en[7] |=> !s_q.clk_en[7] [*3])
        else $error("always-on clock passed faster than four");

    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && paddr == CKP_SEL_A_OFF && pstrb == 4'hf)
        |=> (s_q.sel_a == ($past(pwdata) & CKP_SEL_A_MASK)))
        else $error("select register write lost");

    a_ratio_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ((s_q.cnt & 5'h1f) != 5'h1f && s_q.ratio[23:21] == 3'h5) |=> $stable(s_q.ratio[23:21]))
        else $error("ratio changed inside a period");

    // Bus handshake: one ready pulse per setup, none while idle.
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready)
        else $error("no ready after setup");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready && !pslverr)
        else $error("ready or error without a request");

    // Read data of each register.
    a_sel_a_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == CKP_SEL_A_OFF) |=> (prdata == $past(s_q.sel_a)) && !pslverr)
        else $error("select a read data wrong");

    a_sel_b_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == CKP_SEL_B_OFF) |=> (prdata == $past(s_q.sel_b)) && !pslverr)
        else $error("select b read data wrong");

    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == CKP_STATUS_OFF)
        |=> !pslverr && (prdata[2:0] == $past(s_q.swst)))
        else $error("status read wrong");

    a_status_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == CKP_STATUS_OFF) |=> ((prdata & 32'hf8fefff8) == 32'h0))
        else $error("status reserved bits set");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr != CKP_STATUS_OFF && paddr != CKP_SEL_A_OFF
         && paddr != CKP_SEL_B_OFF) |=> pslverr && (prdata == 32'h0))
        else $error("unmapped access not refused");

    // Select register contents only change through writes to the select registers.
    a_sel_b_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && paddr == CKP_SEL_B_OFF && pstrb == 4'hf)
        |=> (s_q.sel_b == ($past(pwdata) & CKP_SEL_B_MASK)))
        else $error("select b write lost");

    a_ro_nochange: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == CKP_STATUS_OFF)
        |=> $stable(s_q.sel_a) && $stable(s_q.sel_b))
        else $error("status write changed a select");

    a_read_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite) |=> $stable(s_q.sel_a) && $stable(s_q.sel_b))
        else $error("read changed a select");

    a_sel_a_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.sel_a & ~CKP_SEL_A_MASK) == 32'h0)
        else $error("select a reserved bit set");

    a_sel_b_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.sel_b & ~CKP_SEL_B_MASK) == 32'h0)
        else $error("select b reserved bit set");

    // Status tracking.
    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (src_sync_q == $past(src_meta_q)))
        else $error("source synchroniser skipped a stage");

    a_hsi_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (src_sync_q != CKP_SRC_HSI) |=> !s_q.int_usage[0])
        else $error("internal fast usage bit stuck");

    a_hse_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (src_sync_q != CKP_SRC_HSE) |=> !s_q.hse_used)
        else $error("external fast usage bit stuck");

    a_mon_bit: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (s_q.int_usage[2] == $past(mon_sync_q)))
        else $error("monitor usage bit wrong");

    // Divider timing.
    a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (s_q.cnt == $past(s_q.cnt) + 5'h1))
        else $error("divider counter skipped");

    a_div2_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[2:0] == 3'h1 && $stable(s_q.ratio[2:0]) && s_q.clk_en[0]) |=> !s_q.clk_en[0])
        else $error("divide by two spacing wrong");

    a_div4_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[8:6] == 3'h2 && $stable(s_q.ratio[8:6]) && s_q.clk_en[2])
        |=> !s_q.clk_en[2] [*3])
        else $error("divide by four spacing wrong");

    a_div8_period: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[5:3] == 3'h3 && $stable(s_q.ratio[5:3]) && s_q.clk_en[1]) |-> ##8 s_q.clk_en[1])
        else $error("divide by eight pulse missing");

    a_aon_period: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[23:21] == 3'h2 && $stable(s_q.ratio[23:21]) && s_q.clk_en[7])
        |-> ##4 s_q.clk_en[7])
        else $error("always-on divide by four pulse missing");

    a_aon_range: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ratio[23:21] >= 3'h2 && s_q.ratio[23:21] <= 3'h5)
        else $error("always-on ratio out of range");

    a_afio_undiv: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ratio[26:24] == 3'h0) |=> s_q.clk_en[8])
        else $error("alternate-function undivided enable missing");

    a_afio_range: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ratio[26:24] <= 3'h3)
        else $error("alternate-function ratio out of range");

endmodule : ckp_clock_status_prescaler

// ==== core/ckp_pkg.sv ====
package ckp_pkg;

    // Register byte addresses.
    localparam logic [11:0] CKP_STATUS_OFF = 12'h034;
    localparam logic [11:0] CKP_SEL_A_OFF = 12'h038;
    localparam logic [11:0] CKP_SEL_B_OFF = 12'h03c;

    // Reset values.
    localparam logic [31:0] CKP_STATUS_RST = 32'h01000003;
    localparam logic [31:0] CKP_SEL_A_RST = 32'h00000000;
    localparam logic [31:0] CKP_SEL_B_RST = 32'h00000000;

    // Field positions (low bit of each field).
    localparam int CKP_SWST_LSB = 0;
    localparam int CKP_EXT_USE_LSB = 16;
    localparam int CKP_INT_USE_LSB = 24;
    localparam int CKP_MOTOR_LSB = 16;
    localparam int CKP_BT1_LSB = 14;
    localparam int CKP_BT0_LSB = 12;
    localparam int CKP_SPI1_LSB = 6;
    localparam int CKP_SPI0_LSB = 4;
    localparam int CKP_TW1_LSB = 2;
    localparam int CKP_TW0_LSB = 0;
    localparam int CKP_AON_LSB = 14;
    localparam int CKP_AFIO_LSB = 0;

    // Writable bits of each select register.
    localparam logic [31:0] CKP_SEL_A_MASK = 32'h0003f0ff;
    localparam logic [31:0] CKP_SEL_B_MASK = 32'h0000c003;

    // Clock switch status codes.
    localparam logic [2:0] CKP_SRC_HSE = 3'h2;
    localparam logic [2:0] CKP_SRC_HSI = 3'h3;
    localparam logic [2:0] CKP_SRC_LSE = 3'h6;
    localparam logic [2:0] CKP_SRC_LSI = 3'h7;

    // Number of divided clock outputs and divider width.
    localparam int CKP_NCLK = 9;
    localparam int CKP_CW = 5;

    // Divide exponents after reset: the always-on output starts at four, the rest undivided.
    localparam logic [CKP_NCLK*3-1:0] CKP_RATIO_RST = 27'h0400000;

    // Whole state of the block.
    typedef struct packed {
        logic [31:0] sel_a;
        logic [31:0] sel_b;
        logic [2:0] swst;
        logic [2:0] int_usage;
        logic hse_used;
        logic [CKP_CW-1:0] cnt;
        logic [CKP_NCLK*3-1:0] ratio;
        logic [CKP_NCLK-1:0] clk_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ckp_state_t;

endpackage : ckp_pkg

// ==== tb/ckp_testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import ckp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, monitor_uses_hsi, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lfsr, ma, mb, ex;
    logic [3:0] pstrb;
    logic [2:0] clock_switch_select;
    logic [CKP_NCLK-1:0] periph_clk_en;
    logic [2:0] src [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
    int lsb [7] = '{0, 2, 4, 6, 12, 14, 16};
    int mismatches, tests_run, n, c, cnt;

    // Device under test.
    ckp_clock_status_prescaler dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_switch_select(clock_switch_select), .monitor_uses_hsi(monitor_uses_hsi),
        .periph_clk_en(periph_clk_en));

    // Bus clock of 20 ns.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Pseudo-random source for register data.
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    // Compares one value with its expectation and counts the result.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One bus transfer; the request is held until pready is seen at an edge, for at most 20 edges.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Prints the counts and the verdict, then stops the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Cuts a hang short after 20000 cycles.
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    // Main sequence.
    initial begin
        {psel, penable, pwrite, presetn, monitor_uses_hsi} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        clock_switch_select = 3'h3;
        lfsr = 32'h20f3;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CKP_STATUS_OFF, 32'h0);
        check("status reset", rd, 32'h01000003);
        apb(1'b0, CKP_SEL_A_OFF, 32'h0);
        check("sel a reset", rd, 32'h0);
        apb(1'b0, CKP_SEL_B_OFF, 32'h0);
        check("sel b reset", rd, 32'h0);
        for (n = 0; n < 8; n++) begin
            lfsr = next_rand(lfsr);
            ma = lfsr & 32'h0003f0ff;
            apb(1'b1, CKP_SEL_A_OFF, lfsr);
            lfsr = next_rand(lfsr);
            mb = lfsr & 32'h0000c003;
            apb(1'b1, CKP_SEL_B_OFF, lfsr);
            apb(1'b0, CKP_SEL_A_OFF, 32'h0);
            check("sel a", rd, ma);
            apb(1'b0, CKP_SEL_B_OFF, 32'h0);
            check("sel b", rd, mb);
        end
        apb(1'b1, CKP_STATUS_OFF, 32'hffffffff);
        check("status write error", 32'(err), 32'h1);
        apb(1'b0, 12'h040, 32'h0);
        check("unmapped data", rd, 32'h0);
        $display("register test done");
        // Every source code with and without the monitor.
        for (n = 0; n < 2; n++) begin
            for (c = 0; c < 4; c++) begin
                clock_switch_select <= src[c];
                monitor_uses_hsi <= n[0];
                repeat (6) @(posedge pclk);
                apb(1'b0, CKP_STATUS_OFF, 32'h0);
                ex = {5'h0, n[0], 1'b0, src[c] == 3'h3, 6'h0, 1'b0, src[c] == 3'h2, 13'h0, src[c]};
                check("status", rd, ex);
            end
        end
        $display("status test done");
        // Pulse counts of every divided clock over 64 cycles for each code.
        for (n = 0; n < 9; n++) begin
            for (c = 0; c < 4; c++) begin
                apb(1'b1, CKP_SEL_A_OFF, (n < 7) ? 32'(c) << lsb[n] : 32'h0);
                apb(1'b1, CKP_SEL_B_OFF, (n == 7) ? 32'(c) << 14 : (n == 8) ? 32'(c) : 32'h0);
                repeat (40) @(posedge pclk);
                cnt = 0;
                repeat (64) begin
                    @(posedge pclk);
                    cnt += (periph_clk_en[n] === 1'b1);
                end
                check("enable pulses", 32'(cnt), 32'(64 >> ((n == 7) ? c + 2 : c)));
            end
        end
        $display("divider test done");
        finish_test();
    end
endmodule : testbench
